// File: smbcp_host.sv
// bus master model driving the two-wire port from outside
`default_nettype none
module smbcp_host (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output var  logic scl_o,
  output var  logic sda_oe_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // scl stands high between frames
  initial begin
    scl_o = 1'b1;
    sda_oe_n_o = 1'b1;
  end
  ////////////////////////////////////////////////////////////
  // data moves two cycles after scl fall, away from the edge
  task automatic lead(input logic b);
    repeat (2) @(posedge clk_i);
    sda_oe_n_o <= b;
    repeat (4) @(posedge clk_i);
    scl_o <= 1'b1;
    repeat (6) @(posedge clk_i);
  endtask
  task automatic xbit(input logic b, output logic r);
    lead(b);
    r = sda_i;
    scl_o <= 1'b0;
  endtask
  task automatic start_c;
    lead(1'b1);
    sda_oe_n_o <= 1'b0;
    repeat (6) @(posedge clk_i);
    scl_o <= 1'b0;
  endtask
  task automatic stop_c;
    lead(1'b0);
    sda_oe_n_o <= 1'b1;
    repeat (6) @(posedge clk_i);
  endtask
  task automatic xbyte(input logic [7:0] d, input logic a_in, output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--) xbit(d[i], q[i]);
    xbit(a_in, a);
  endtask
endmodule // smbcp_host
`default_nettype wire

// File: smbcp_map.vh
// constants for the two-wire configuration port of the clock buffer
`ifndef SMBCP_MAP_VH
`define SMBCP_MAP_VH

`define SMBCP_SLAVE_ADDR    8'hd2
`define SMBCP_CMD_BLOCK     8'h00
`define SMBCP_CMD_SINGLE_B  7
`define SMBCP_NUM_BYTES     3
`define SMBCP_NUM_PAIRS     19
`define SMBCP_NUM_OE_PINS   8
`define SMBCP_OE_FIRST_PAIR 5
`define SMBCP_BYTE0_RST     8'h38
`define SMBCP_BYTE1_RST     8'hff
`define SMBCP_BYTE2_RST     8'hff
`define SMBCP_BYTE0_WMASK   8'h3e
`define SMBCP_LOW_PAIRS     16
`define SMBCP_LOW_PAIR_BIT  8
`define SMBCP_HIGH_PAIR_OFS 13
`define SMBCP_RD_PAD        8'hff

`endif

// File: smbcp_monitor.sv
// concurrent checks on the two-wire port pins and pair enables
`default_nettype none
module smbcp_monitor #(
  parameter NUM_PAIRS = 19,
  parameter NUM_OE    = 8
) (
  input wire logic                 clk_i,
  input wire logic                 reset_n_i,
  input wire logic                 scl_i,
  input wire logic                 sda_i,
  input wire logic                 sda_o,
  input wire logic                 sda_oe_n_o,
  input wire logic [NUM_OE-1:0]    pair_oe_n_i,
  input wire logic [1:0]           pll_mode_i,
  input wire logic                 freq_sel_i,
  input wire logic [NUM_PAIRS-1:0] clock_pair_en_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  ////////////////////////////////////////////////////////////
  a_sda_value_zero: assert property (sda_o == 1'b0) else $error("sda value not zero");
  a_reset_pairs_on: assert property ($rose(reset_n_i) |-> &clock_pair_en_o ##1 &clock_pair_en_o)
    else $error("pairs off at reset");
  a_pin_gates_pair: assert property ((pair_oe_n_i == {NUM_OE{1'b1}}) [*5] |-> clock_pair_en_o[12:5] == 8'h00)
    else $error("pin high but pair on");
  a_hold_scl_high: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe_n_o)) else $error("drive moved, scl high");
  a_drive_after_fall: assert property ($fell(sda_oe_n_o) |-> !scl_i && !$past(scl_i, 2))
    else $error("drive not after scl fall");
  a_drive_stands: assert property ($fell(sda_oe_n_o) |=> !sda_oe_n_o [*4]) else $error("drive too short");
  a_release_bound: assert property ($fell(sda_oe_n_o) |-> ##[1:110] sda_oe_n_o) else $error("drive never released");
  // idle bus long enough: any write has long landed
  a_idle_pairs_kept: assert property ((scl_i && sda_i) [*8] |=>
    $stable({clock_pair_en_o[18:13], clock_pair_en_o[4:0]})) else $error("pairs moved on idle bus");
  c_drive: cover property ($fell(sda_oe_n_o));
  c_gated: cover property (clock_pair_en_o[12:5] == 8'h00);
  c_stop: cover property ($rose(sda_i) && scl_i);
endmodule // smbcp_monitor
bind smbcp_port smbcp_monitor #(.NUM_PAIRS(NUM_PAIRS), .NUM_OE(NUM_OE)) u_mon (.clk_i, .reset_n_i, .scl_i,
  .sda_i, .sda_o, .sda_oe_n_o, .pair_oe_n_i, .pll_mode_i, .freq_sel_i, .clock_pair_en_o);
`default_nettype wire

// File: smbcp_port.v
// two-wire slave port holding the configuration bytes and output pair enables
`include "smbcp_map.vh"
`default_nettype none

module smbcp_port #(
  parameter                         NUM_BYTES = `SMBCP_NUM_BYTES,
  parameter                         NUM_PAIRS = `SMBCP_NUM_PAIRS,
  parameter                         NUM_OE    = `SMBCP_NUM_OE_PINS,
  parameter [8*NUM_BYTES-1:0]       CFG_RST   = {`SMBCP_BYTE2_RST, `SMBCP_BYTE1_RST, `SMBCP_BYTE0_RST}
) (
  input  wire                 clk_i,
  input  wire                 reset_n_i,
  input  wire                 scl_i,
  input  wire                 sda_i,
  output wire                 sda_o,
  output wire                 sda_oe_n_o,
  input  wire [NUM_OE-1:0]    pair_oe_n_i,
  input  wire [1:0]           pll_mode_i,
  input  wire                 freq_sel_i,
  output wire [NUM_PAIRS-1:0] clock_pair_en_o
);

  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_RX   = 3'h1;
  localparam [2:0] S_ACK  = 3'h2;
  localparam [2:0] S_TX   = 3'h3;
  localparam [2:0] S_RACK = 3'h4;

  localparam [1:0] K_ADDR = 2'h0;
  localparam [1:0] K_CMD  = 2'h1;
  localparam [1:0] K_CNT  = 2'h2;
  localparam [1:0] K_DATA = 2'h3;
  localparam SW = NUM_OE + 5;

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and edge detection

  wire [SW-1:0] sync_w;
  wire          scl_s;
  wire          sda_s;
  wire [NUM_OE-1:0] oe_n_s;
  wire [1:0]    mode_s;
  wire          freq_s;

  smbcp_sync #(
    .W       (SW),
    .RST_VAL ({2'b11, {NUM_OE{1'b0}}, 3'b000})
  ) u_sync (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .d_i       ({scl_i, sda_i, pair_oe_n_i, pll_mode_i, freq_sel_i}),
    .q_o       (sync_w)
  );

  assign scl_s  = sync_w[SW-1];
  assign sda_s  = sync_w[SW-2];
  assign oe_n_s = sync_w[SW-3:3];
  assign mode_s = sync_w[2:1];
  assign freq_s = sync_w[0];

  reg scl_p_q;
  reg sda_p_q;
  reg drive_low_q;
  reg sda_oe_n_q;

  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      scl_p_q    <= 1'b1;
      sda_p_q    <= 1'b1;
      sda_oe_n_q <= 1'b1;
    end else begin
      scl_p_q    <= scl_s;
      sda_p_q    <= sda_s;
      sda_oe_n_q <= ~drive_low_q;
    end
  end

  wire scl_rise = scl_s & ~scl_p_q;
  wire scl_fall = ~scl_s & scl_p_q;
  // start or repeated start: data falls while clock high
  wire start_ev = scl_s & scl_p_q & sda_p_q & ~sda_s;
  wire stop_ev  = scl_s & scl_p_q & ~sda_p_q & sda_s;

  //////////////////////////////////////////////////////////////////////////////
  // protocol engine

  reg [2:0]             st_q;
  reg [1:0]             kind_q;
  reg [3:0]             bit_cnt_q;
  reg [7:0]             sh_q;
  reg [6:0]             ptr_q;
  reg                   block_q;
  reg                   cnt_pend_q;
  reg                   tx_next_q;
  reg                   mack_q;
  reg [8*NUM_BYTES-1:0] cfg_q;

  // byte presented to the master, status bits overlaid on byte zero
  wire [7:0] rd_raw  = (ptr_q < NUM_BYTES) ? cfg_q[ptr_q*8 +: 8] : `SMBCP_RD_PAD;
  wire [7:0] rd_cfg  = (ptr_q == 7'h00) ? {mode_s, rd_raw[5:1], freq_s} : rd_raw;
  wire [7:0] cnt_val = NUM_BYTES[7:0];
  wire [7:0] rd_byte = (block_q && cnt_pend_q) ? cnt_val : rd_cfg;
  wire       rd_adv  = ~(block_q && cnt_pend_q);
  wire [7:0] wmask   = (ptr_q == 7'h00) ? `SMBCP_BYTE0_WMASK : 8'hff;

  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_q        <= S_IDLE;
      kind_q      <= K_ADDR;
      bit_cnt_q   <= 4'h0;
      sh_q        <= 8'h00;
      ptr_q       <= 7'h00;
      block_q     <= 1'b0;
      cnt_pend_q  <= 1'b0;
      tx_next_q   <= 1'b0;
      mack_q      <= 1'b0;
      drive_low_q <= 1'b0;
      cfg_q       <= CFG_RST;
    end else if (start_ev) begin
      st_q        <= S_RX;
      kind_q      <= K_ADDR;
      bit_cnt_q   <= 4'h0;
      drive_low_q <= 1'b0;
    end else if (stop_ev) begin
      st_q        <= S_IDLE;
      drive_low_q <= 1'b0;
    end else begin
      case (st_q)
        S_RX: begin
          if (scl_rise) begin
            sh_q      <= {sh_q[6:0], sda_s};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else if (scl_fall && bit_cnt_q == 4'h8) begin
            st_q        <= S_ACK;
            drive_low_q <= 1'b1;
            tx_next_q   <= 1'b0;
            case (kind_q)
              K_ADDR: begin
                if ({sh_q[7:1], 1'b0} != `SMBCP_SLAVE_ADDR) begin
                  st_q        <= S_IDLE;
                  drive_low_q <= 1'b0;
                end else if (sh_q[0]) begin
                  tx_next_q  <= 1'b1;
                  cnt_pend_q <= 1'b1;
                end else begin
                  kind_q <= K_CMD;
                end
              end
              K_CMD: begin
                ptr_q <= 7'h00;
                if (sh_q == `SMBCP_CMD_BLOCK) begin
                  block_q <= 1'b1;
                  kind_q  <= K_CNT;
                end else if (sh_q[`SMBCP_CMD_SINGLE_B]) begin
                  block_q <= 1'b0;
                  ptr_q   <= sh_q[6:0];
                  kind_q  <= K_DATA;
                end else begin
                  // unknown command: refuse with a nack
                  st_q        <= S_IDLE;
                  drive_low_q <= 1'b0;
                end
              end
              K_CNT: begin
                kind_q <= K_DATA;
              end
              default: begin
                if (ptr_q < NUM_BYTES) begin
                  cfg_q[ptr_q*8 +: 8] <= (cfg_q[ptr_q*8 +: 8] & ~wmask) | (sh_q & wmask);
                end
                ptr_q <= ptr_q + 7'h01;
              end
            endcase
          end
        end
        S_ACK: begin
          if (scl_fall) begin
            bit_cnt_q <= 4'h0;
            if (tx_next_q) begin
              st_q        <= S_TX;
              sh_q        <= rd_byte;
              drive_low_q <= ~rd_byte[7];
              cnt_pend_q  <= 1'b0;
              if (rd_adv) begin
                ptr_q <= ptr_q + 7'h01;
              end
            end else begin
              st_q        <= S_RX;
              drive_low_q <= 1'b0;
            end
          end
        end
        S_TX: begin
          if (scl_rise) begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt_q == 4'h8) begin
              st_q        <= S_RACK;
              drive_low_q <= 1'b0;
            end else begin
              sh_q        <= {sh_q[6:0], 1'b0};
              drive_low_q <= ~sh_q[6];
            end
          end
        end
        S_RACK: begin
          if (scl_rise) begin
            mack_q <= ~sda_s;
          end else if (scl_fall) begin
            bit_cnt_q <= 4'h0;
            if (mack_q) begin
              st_q        <= S_TX;
              sh_q        <= rd_byte;
              drive_low_q <= ~rd_byte[7];
              if (rd_adv) begin
                ptr_q <= ptr_q + 7'h01;
              end
            end else begin
              st_q <= S_IDLE;
            end
          end
        end
        default: begin
          drive_low_q <= 1'b0;
        end
      endcase
    end
  end

  // open-drain data: only ever pulls low; enable pin leaves a flop, one cycle late
  assign sda_o      = 1'b0;
  assign sda_oe_n_o = sda_oe_n_q;

  //////////////////////////////////////////////////////////////////////////////
  // output pair enables

  reg [NUM_PAIRS-1:0] pair_en_q;
  genvar g;
  generate
    for (g = 0; g < NUM_PAIRS; g = g + 1) begin : g_pair
      wire pin_ok;
      wire bit_ok;
      if (g >= `SMBCP_OE_FIRST_PAIR && g < `SMBCP_OE_FIRST_PAIR + NUM_OE) begin : g_pin
        assign pin_ok = ~oe_n_s[g - `SMBCP_OE_FIRST_PAIR];
      end else begin : g_nopin
        assign pin_ok = 1'b1;
      end
      if (g < `SMBCP_LOW_PAIRS) begin : g_lo
        assign bit_ok = cfg_q[`SMBCP_LOW_PAIR_BIT + g];
      end else begin : g_hi
        assign bit_ok = cfg_q[g - `SMBCP_HIGH_PAIR_OFS];
      end
      always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          pair_en_q[g] <= 1'b1;
        end else begin
          pair_en_q[g] <= pin_ok & bit_ok;
        end
      end
    end
  endgenerate

  assign clock_pair_en_o = pair_en_q;

endmodule // smbcp_port
`default_nettype wire

// File: smbcp_sync.v
// two-flop synchroniser for pins from outside the clock domain
`default_nettype none

module smbcp_sync #(
  parameter         W       = 1,
  parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
  input  wire         clk_i,
  input  wire         reset_n_i,
  input  wire [W-1:0] d_i,
  output wire [W-1:0] q_o
);

  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  // first stage feeds only the second stage
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;

endmodule // smbcp_sync

`default_nettype wire

// File: tb.sv
// self-checking bench for the two-wire configuration port
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("wrong value %s exp %h got %h", nm, e, g); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic [7:0]  pins = 8'h00;
  logic [1:0]  pll_mode = 2'b10;
  logic        fsel = 1'b1;
  wire  logic  scl, m_oe_n, d_oe_n, d_sda;
  wire  logic [18:0] pairs;
  // pull-up: low if anyone pulls
  wire  logic  sda = m_oe_n & d_oe_n;
  int          n_mismatch = 0;
  int          n_checks = 0;
  logic [7:0]  q;
  logic        a;
  always #2 clk_i = ~clk_i;
  smbcp_port DUT (.clk_i(clk_i), .reset_n_i(reset_n_i), .scl_i(scl), .sda_i(sda), .sda_o(d_sda),
    .sda_oe_n_o(d_oe_n), .pair_oe_n_i(pins), .pll_mode_i(pll_mode), .freq_sel_i(fsel), .clock_pair_en_o(pairs));
  smbcp_host u_host (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_oe_n_o(m_oe_n));
  ////////////////////////////////////////////////////////////
  task automatic tx(input logic [7:0] d, input logic e);
    u_host.xbyte(d, 1'b1, q, a);
    `CHK("ack", e, a)
  endtask
  task automatic rx(input logic [7:0] e, input logic last);
    u_host.xbyte(8'hff, last, q, a);
    `CHK("read byte", e, q)
  endtask
  task automatic hdr(input logic [7:0] cmd, input logic e);
    u_host.start_c();
    tx(8'hd2, 1'b0);
    tx(cmd, e);
  endtask
  task automatic settle;
    repeat (8) @(posedge clk_i);
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_block_wr;
    hdr(8'h00, 1'b0);
    tx(8'h03, 1'b0);
    tx(8'hc5, 1'b0);
    tx(8'h5a, 1'b0);
    tx(8'h0f, 1'b0);
    u_host.stop_c();
    settle;
    `CHK("pairs", 19'h00f5a, pairs)
    pins <= 8'hff;
    settle;
    `CHK("gated", 19'h0001a, pairs)
    pins <= 8'h00;
  endtask
  task automatic t_block_rd;
    hdr(8'h00, 1'b0);
    u_host.start_c();
    tx(8'hd3, 1'b0);
    rx(8'h03, 1'b0);
    rx(8'h85, 1'b0);
    rx(8'h5a, 1'b0);
    rx(8'h0f, 1'b1);
    u_host.stop_c();
  endtask
  task automatic t_refuse;
    u_host.start_c();
    tx(8'hd4, 1'b1);
    u_host.stop_c();
    hdr(8'h01, 1'b1);
    u_host.stop_c();
  endtask
  // a short block then a single byte at offset two
  task automatic t_single;
    hdr(8'h00, 1'b0);
    tx(8'h03, 1'b0);
    tx(8'h38, 1'b0);
    u_host.stop_c();
    hdr(8'h82, 1'b0);
    tx(8'hf0, 1'b0);
    u_host.stop_c();
    settle;
    `CHK("pairs", 19'h7f05a, pairs)
    hdr(8'h81, 1'b0);
    u_host.start_c();
    tx(8'hd3, 1'b0);
    rx(8'h5a, 1'b1);
    u_host.stop_c();
  endtask
  task automatic give_verdict;
    if (n_mismatch == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk_i);
    reset_n_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    `CHK("reset pairs", 19'h7ffff, pairs)
    t_block_wr;
    t_block_rd;
    t_refuse;
    t_single;
    give_verdict;
  end
  // run needs about 13 us of bus traffic
  initial begin
    #200000;
    n_mismatch++;
    give_verdict;
  end
endmodule // tb
`default_nettype wire
